// ==== verilog/reference_config_mailbox.sv ====
/*
 * reference configuration mailbox: page registers, semaphore triggers,
 * per-reference configuration store and expected frequency divider.
 * assumes an avalon-mm master on clk_in that holds each request until it
 * samples waitrequest low; reset is asynchronous, active low.
 */
module reference_config_mailbox (
  // clock and reset
  input  wire logic                                          clk_in,
  input  wire logic                                          rst_n_in,
  // avalon-mm slave
  input  wire logic [refmbox_pkg::ADDR_W-1:0]                avs_address_in,
  input  wire logic                                          avs_read_in,
  input  wire logic                                          avs_write_in,
  input  wire logic [refmbox_pkg::DATA_W-1:0]                avs_writedata_in,
  input  wire logic [3:0]                                    avs_byteenable_in,
  output logic      [refmbox_pkg::DATA_W-1:0]                avs_readdata_out,
  output logic                                               avs_waitrequest_out,
  // configuration towards the reference inputs
  output refmbox_pkg::ref_cfg_s [refmbox_pkg::NUM_REFS-1:0]  ref_cfg_out,
  output logic      [refmbox_pkg::FREQ_W-1:0]                expected_hz_out
);

  // ****************************************
  // state
  // ****************************************
  refmbox_pkg::mbox_state_e                         state_ff;
  refmbox_pkg::ref_cfg_s                            page_ff;
  refmbox_pkg::ref_cfg_s [refmbox_pkg::NUM_REFS-1:0] cfg_ff;
  logic [refmbox_pkg::NUM_REFS-1:0]                 mask_ff;
  logic [7:0]                                       sem_ff;
  logic [3:0]                                       ref_idx_ff;
  logic                                             wait_ff;
  logic [refmbox_pkg::DATA_W-1:0]                   rdata_ff;
  logic [5:0]                                       div_cnt_ff;
  logic [refmbox_pkg::FIELD_W:0]                    div_rem_ff;
  logic [refmbox_pkg::FREQ_W-1:0]                   div_quo_ff;
  logic [refmbox_pkg::FREQ_W-1:0]                   expected_ff;

  logic [refmbox_pkg::IDX_W-1:0]                    idx;
  logic                                             wr_go;
  logic                                             idle;
  logic [refmbox_pkg::FIELD_W:0]                    trial;
  logic                                             fits;
  logic [refmbox_pkg::FREQ_W-1:0]                   nxt_quo;

  assign idx   = avs_address_in[refmbox_pkg::ADDR_W-1:2];
  assign wr_go = avs_write_in && !wait_ff;
  assign idle  = (state_ff == refmbox_pkg::ST_IDLE);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                          input logic [31:0] wdata,
                                          input logic [3:0]  be);
    logic [15:0] res;
    res = old_val;
    if (be[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  function automatic logic [3:0] lowest_set(input logic [11:0] mask);
    logic [3:0] pos;
    pos = 4'h0;
    for (int i = 11; i >= 0; i--) begin
      if (mask[i]) begin
        pos = 4'(i);
      end
    end
    return pos;
  endfunction

  // ****************************************
  // bus handshake: one wait cycle per access
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_ff <= 1'b1;
    end else if (wait_ff && (avs_read_in || avs_write_in)) begin
      wait_ff <= 1'b0;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 32'h0000_0000;
    end else if (wait_ff && avs_read_in) begin
      unique case (idx)
        refmbox_pkg::IDX_MASK:      rdata_ff <= {20'h00000, mask_ff};
        refmbox_pkg::IDX_SEMAPHORE: rdata_ff <= {24'h000000, sem_ff};
        refmbox_pkg::IDX_BASE:      rdata_ff <= {16'h0000, page_ff.base_hz};
        refmbox_pkg::IDX_MULT:      rdata_ff <= {16'h0000, page_ff.base_multiple};
        refmbox_pkg::IDX_NUM:       rdata_ff <= {16'h0000, page_ff.fec_numerator};
        refmbox_pkg::IDX_DEN:       rdata_ff <= {16'h0000, page_ff.fec_denominator};
        default:                    rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // reference mask
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mask_ff <= refmbox_pkg::MASK_RST;
    end else if (wr_go && idle && idx == refmbox_pkg::IDX_MASK) begin
      if (avs_byteenable_in[0]) begin
        mask_ff[7:0] <= avs_writedata_in[7:0];
      end
      if (avs_byteenable_in[1]) begin
        mask_ff[11:8] <= avs_writedata_in[11:8];
      end
    end
  end

  // ****************************************
  // semaphore and sequencer
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff   <= refmbox_pkg::ST_IDLE;
      sem_ff     <= refmbox_pkg::SEM_RST;
      ref_idx_ff <= 4'h0;
    end else begin
      unique case (state_ff)
        refmbox_pkg::ST_IDLE: begin
          // busy writes never reach here, so they are dropped
          if (wr_go && idx == refmbox_pkg::IDX_SEMAPHORE && avs_byteenable_in[0]) begin
            if (avs_writedata_in[refmbox_pkg::SEM_FETCH_BIT]) begin
              state_ff <= refmbox_pkg::ST_FETCH;
              sem_ff   <= refmbox_pkg::SEM_FETCH;
            end else if (avs_writedata_in[refmbox_pkg::SEM_COMMIT_BIT]) begin
              state_ff   <= refmbox_pkg::ST_COMMIT;
              sem_ff     <= refmbox_pkg::SEM_COMMIT;
              ref_idx_ff <= 4'h0;
            end
          end
        end
        refmbox_pkg::ST_FETCH: begin
          state_ff <= refmbox_pkg::ST_IDLE;
          sem_ff   <= refmbox_pkg::SEM_RST;
        end
        refmbox_pkg::ST_COMMIT: begin
          if (ref_idx_ff == refmbox_pkg::LAST_REF) begin
            state_ff <= refmbox_pkg::ST_IDLE;
            sem_ff   <= refmbox_pkg::SEM_RST;
          end else begin
            ref_idx_ff <= ref_idx_ff + 4'h1;
          end
        end
        default: begin
          state_ff <= refmbox_pkg::ST_IDLE;
          sem_ff   <= refmbox_pkg::SEM_RST;
        end
      endcase
    end
  end

  // ****************************************
  // page registers
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      page_ff <= refmbox_pkg::CFG_RST;
    end else if (state_ff == refmbox_pkg::ST_FETCH) begin
      if (|mask_ff) begin
        page_ff <= cfg_ff[lowest_set(mask_ff)];
      end
    end else if (wr_go && idle) begin
      unique case (idx)
        refmbox_pkg::IDX_BASE:
          page_ff.base_hz <= merge16(page_ff.base_hz, avs_writedata_in,
                                     avs_byteenable_in);
        refmbox_pkg::IDX_MULT:
          page_ff.base_multiple <= merge16(page_ff.base_multiple, avs_writedata_in,
                                           avs_byteenable_in);
        refmbox_pkg::IDX_NUM:
          page_ff.fec_numerator <= merge16(page_ff.fec_numerator, avs_writedata_in,
                                           avs_byteenable_in);
        refmbox_pkg::IDX_DEN:
          page_ff.fec_denominator <= merge16(page_ff.fec_denominator, avs_writedata_in,
                                             avs_byteenable_in);
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // per-reference store, one reference per cycle
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_ff <= {refmbox_pkg::NUM_REFS{refmbox_pkg::CFG_RST}};
    end else if (state_ff == refmbox_pkg::ST_COMMIT && mask_ff[ref_idx_ff]) begin
      cfg_ff[ref_idx_ff] <= page_ff;
    end
  end

  // ****************************************
  // expected frequency: serial restoring divide
  // ****************************************
  assign trial   = {div_rem_ff[refmbox_pkg::FIELD_W-1:0], div_quo_ff[refmbox_pkg::FREQ_W-1]};
  assign fits    = (trial >= {1'b0, page_ff.fec_denominator});
  assign nxt_quo = {div_quo_ff[refmbox_pkg::FREQ_W-2:0], fits};

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt_ff  <= 6'h00;
      div_rem_ff  <= 17'h00000;
      div_quo_ff  <= 48'h0000_0000_0000;
      expected_ff <= 48'h0000_0000_0000;
    end else if (div_cnt_ff == 6'h00) begin
      div_cnt_ff <= refmbox_pkg::DIV_STEPS;
      div_rem_ff <= 17'h00000;
      div_quo_ff <= page_ff.base_hz * page_ff.base_multiple
                    * page_ff.fec_numerator;
    end else begin
      div_cnt_ff <= div_cnt_ff - 6'h01;
      div_rem_ff <= fits ? (trial - {1'b0, page_ff.fec_denominator}) : trial;
      div_quo_ff <= nxt_quo;
      if (div_cnt_ff == 6'h01) begin
        expected_ff <= nxt_quo;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign avs_readdata_out    = rdata_ff;
  assign avs_waitrequest_out = wait_ff;
  assign ref_cfg_out         = cfg_ff;
  assign expected_hz_out     = expected_ff;

endmodule

// ==== verilog/refmbox_pkg.sv ====
/*
 * constants, types and register map of the reference configuration mailbox.
 * assumes a 32-bit avalon-mm slave port with byte addresses, each register
 * index standing at byte address four times its index.
 */
package refmbox_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_REFS = 12;
  localparam int FIELD_W  = 16;
  localparam int ADDR_W   = 14;
  localparam int DATA_W   = 32;
  localparam int FREQ_W   = 48;
  localparam int IDX_W    = 12;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [IDX_W-1:0] IDX_MASK      = 12'h582;
  localparam logic [IDX_W-1:0] IDX_SEMAPHORE = 12'h584;
  localparam logic [IDX_W-1:0] IDX_BASE      = 12'h585;
  localparam logic [IDX_W-1:0] IDX_MULT      = 12'h587;
  localparam logic [IDX_W-1:0] IDX_NUM       = 12'h589;
  localparam logic [IDX_W-1:0] IDX_DEN       = 12'h58b;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int              SEM_COMMIT_BIT = 0;
  localparam int              SEM_FETCH_BIT  = 1;
  localparam logic [7:0]      SEM_RST        = 8'h00;
  localparam logic [7:0]      SEM_COMMIT     = 8'h01;
  localparam logic [7:0]      SEM_FETCH      = 8'h02;
  localparam logic [11:0]     MASK_RST       = 12'h001;
  localparam logic [15:0]     BASE_RST       = 16'h9c40;
  localparam logic [15:0]     MULT_RST       = 16'h0001;
  localparam logic [15:0]     NUM_RST        = 16'h0001;
  localparam logic [15:0]     DEN_RST        = 16'h0001;
  localparam logic [3:0]      LAST_REF       = 4'hb;
  localparam logic [5:0]      DIV_STEPS      = 6'h30;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [FIELD_W-1:0] base_hz;
    logic [FIELD_W-1:0] base_multiple;
    logic [FIELD_W-1:0] fec_numerator;
    logic [FIELD_W-1:0] fec_denominator;
  } ref_cfg_s;

  localparam ref_cfg_s CFG_RST = '{BASE_RST, MULT_RST, NUM_RST, DEN_RST};

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_FETCH  = 2'b01,
    ST_COMMIT = 2'b10
  } mbox_state_e;

endpackage

// ==== dv/refmbox_assertions.sv ====
/*
 * checker for the reference configuration mailbox, bound to its top module.
 * assumes the avalon-mm master holds each request until waitrequest is low.
 */
module refmbox_checker (
  // clock and reset
  input wire logic                                         clk_in,
  input wire logic                                         rst_n_in,
  // avalon-mm slave
  input wire logic [refmbox_pkg::ADDR_W-1:0]               avs_address_in,
  input wire logic                                         avs_read_in,
  input wire logic                                         avs_write_in,
  input wire logic [refmbox_pkg::DATA_W-1:0]               avs_writedata_in,
  input wire logic [3:0]                                   avs_byteenable_in,
  input wire logic [refmbox_pkg::DATA_W-1:0]               avs_readdata_out,
  input wire logic                                         avs_waitrequest_out,
  // reference side
  input wire refmbox_pkg::ref_cfg_s [refmbox_pkg::NUM_REFS-1:0] ref_cfg_out,
  input wire logic [refmbox_pkg::FREQ_W-1:0]               expected_hz_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_ff;
  logic [7:0] trig_ff;
  wire        sem_wr = avs_write_in && !avs_waitrequest_out && cnt_ff == 4'h0 &&
                       avs_address_in[13:2] == refmbox_pkg::IDX_SEMAPHORE &&
                       avs_byteenable_in[0] && avs_writedata_in[1:0] != 2'b00;
  wire        rd_ok  = avs_read_in && !avs_waitrequest_out;

  // busy shadow: one cycle per fetch, one per reference per commit
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff  <= 4'h0;
      trig_ff <= 8'h00;
    end else if (sem_wr) begin
      cnt_ff  <= avs_writedata_in[1] ? 4'h1 : 4'hc;
      trig_ff <= avs_writedata_in[1] ? refmbox_pkg::SEM_FETCH : refmbox_pkg::SEM_COMMIT;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_sem_read;
    rd_ok && avs_address_in[13:2] == refmbox_pkg::IDX_SEMAPHORE |->
      avs_readdata_out == {24'h0, ($past(cnt_ff) == 4'h0) ? 8'h00 : $past(trig_ff)};
  endproperty
  a_sem_read: assert property (p_sem_read) else $error("semaphore readback wrong");
  property p_ack;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=>
      !avs_waitrequest_out ##1 avs_waitrequest_out;
  endproperty
  a_ack: assert property (p_ack) else $error("access not answered in one cycle");
  property p_idle;
    !(avs_read_in || avs_write_in) && avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_idle: assert property (p_idle) else $error("waitrequest dropped without request");
  property p_upper;
    rd_ok |-> avs_readdata_out[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_reset_cfg;
    $rose(rst_n_in) |-> ref_cfg_out == {refmbox_pkg::NUM_REFS{refmbox_pkg::CFG_RST}};
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("reference reset value");
  property p_reset_bus;
    $rose(rst_n_in) |-> avs_waitrequest_out && avs_readdata_out == 32'h0 &&
      expected_hz_out == 48'h0;
  endproperty
  a_reset_bus: assert property (p_reset_bus) else $error("bus reset value");
  property p_exp_hold;
    !$stable(expected_hz_out) |=> $stable(expected_hz_out) [*8];
  endproperty
  a_exp_hold: assert property (p_exp_hold) else $error("expected frequency unsteady");
  for (genvar i = 0; i < refmbox_pkg::NUM_REFS; i++) begin : g_ref
    property p_ref_slot;
      !$stable(ref_cfg_out[i]) |-> $past(trig_ff) == refmbox_pkg::SEM_COMMIT &&
        $past(cnt_ff) == 4'(refmbox_pkg::NUM_REFS - i);
    endproperty
    a_ref_slot: assert property (p_ref_slot) else $error("reference updated off slot");
  end
endmodule

bind reference_config_mailbox refmbox_checker u_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .ref_cfg_out(ref_cfg_out), .expected_hz_out(expected_hz_out));

// ==== dv/reference_config_mailbox_test.sv ====
/*
 * self-checking bench for the reference configuration mailbox.
 * assumes the package and design compiled first and the checker bound.
 */
module reference_config_mailbox_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                                              clk_in = 1'b0;
  logic                                              rst_n_in = 1'b0;
  logic [13:0]                                       avs_address_in = 14'h0;
  logic                                              avs_read_in = 1'b0;
  logic                                              avs_write_in = 1'b0;
  logic [31:0]                                       avs_writedata_in = 32'h0;
  logic [3:0]                                        avs_byteenable_in = 4'hf;
  logic [31:0]                                       avs_readdata_out;
  logic                                              avs_waitrequest_out;
  refmbox_pkg::ref_cfg_s [refmbox_pkg::NUM_REFS-1:0] ref_cfg_out;
  logic [47:0]                                       expected_hz_out;
  int                                                n_fail = 0;
  int                                                checks_done = 0;
  refmbox_pkg::ref_cfg_s                             pg = '{16'h9c40, 16'h01e6, 16'h3, 16'h7};

  always #25 clk_in = ~clk_in;

  reference_config_mailbox dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .ref_cfg_out(ref_cfg_out),
    .expected_hz_out(expected_hz_out));

  // ****************************************
  // bus and compare helpers
  // ****************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
                      input logic [3:0] be, output logic [31:0] rd);
    int n;
    @(posedge clk_in);
    avs_address_in <= {idx, 2'b00};
    avs_read_in <= !wr;
    avs_write_in <= wr;
    avs_writedata_in <= wd;
    avs_byteenable_in <= be;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    if (n >= 20) chk(1'b1, 1'b0, "no answer");
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, idx, d, 4'hf, r);
  endtask
  task automatic rd_chk(input logic [11:0] idx, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, idx, 32'h0, 4'hf, r);
    chk(r, e, "readback");
  endtask
  task automatic wait_done();
    logic [31:0] r;
    int n;
    n = 0;
    do begin
      xfer(1'b0, refmbox_pkg::IDX_SEMAPHORE, 32'h0, 4'hf, r);
      n++;
    end while (r !== 32'h0 && n < 40);
    chk(r, 32'h0, "semaphore never cleared");
  endtask
  task automatic set_page(input refmbox_pkg::ref_cfg_s e);
    wr(refmbox_pkg::IDX_BASE, {16'h0, e.base_hz});
    wr(refmbox_pkg::IDX_MULT, {16'h0, e.base_multiple});
    wr(refmbox_pkg::IDX_NUM, {16'h0, e.fec_numerator});
    wr(refmbox_pkg::IDX_DEN, {16'h0, e.fec_denominator});
  endtask
  task automatic chk_page(input refmbox_pkg::ref_cfg_s e);
    rd_chk(refmbox_pkg::IDX_BASE, {16'h0, e.base_hz});
    rd_chk(refmbox_pkg::IDX_MULT, {16'h0, e.base_multiple});
    rd_chk(refmbox_pkg::IDX_NUM, {16'h0, e.fec_numerator});
    rd_chk(refmbox_pkg::IDX_DEN, {16'h0, e.fec_denominator});
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk_page(refmbox_pkg::CFG_RST);
    rd_chk(refmbox_pkg::IDX_SEMAPHORE, 32'h0);
    rd_chk(12'h7ff, 32'h0);
    repeat (60) @(posedge clk_in);
    chk(expected_hz_out, 48'd40000, "reset frequency");
  endtask
  task automatic t_freq();
    set_page(pg);
    repeat (110) @(posedge clk_in);
    chk(expected_hz_out, 48'd40000 * 48'd486 * 48'd3 / 48'd7, "expected frequency");
  endtask
  task automatic t_commit();
    logic [11:0] m;
    m = 12'h821;
    wr(refmbox_pkg::IDX_MASK, {20'h0, m});
    wr(refmbox_pkg::IDX_SEMAPHORE, 32'h1);
    rd_chk(refmbox_pkg::IDX_SEMAPHORE, 32'h1);
    wr(refmbox_pkg::IDX_BASE, 32'h1234);
    wr(refmbox_pkg::IDX_SEMAPHORE, 32'h2);
    wait_done();
    chk_page(pg);
    for (int i = 0; i < refmbox_pkg::NUM_REFS; i++) begin
      chk(ref_cfg_out[i], m[i] ? pg : refmbox_pkg::CFG_RST, "commit");
    end
  endtask
  task automatic t_fetch();
    set_page('{16'h07d0, 16'h0008, 16'h1, 16'h1});
    wr(refmbox_pkg::IDX_MASK, 32'h20);
    wr(refmbox_pkg::IDX_SEMAPHORE, 32'h2);
    wait_done();
    chk_page(pg);
  endtask
  task automatic t_both();
    wr(refmbox_pkg::IDX_MASK, 32'h2);
    wr(refmbox_pkg::IDX_SEMAPHORE, 32'h3);
    wait_done();
    chk_page(refmbox_pkg::CFG_RST);
    chk(ref_cfg_out[1], refmbox_pkg::CFG_RST, "commit not ignored");
  endtask

  task automatic finish_test();
    $display("checks %0d, failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_freq();
    t_commit();
    t_fetch();
    t_both();
    finish_test();
  end
  initial begin
    repeat (4000) @(posedge clk_in);
    n_fail++;
    finish_test();
  end
endmodule
